//--- spfpc_pkg.sv
// Constants, types and decode helpers of the SPI frame protocol checker.
// Assumes a 16-bit command frame, MSB first, and a 16 x 8 register store.
//
// Function
// - The answer to a frame is shifted out only during the next transfer, never the same one.
// - A transfer whose clock count is not 16, 24 or 32 earns an error reply; the code judges a transfer with no clock on the previous count and word.
// - After power-on or software reset the first reply is a fixed post-reset word, unless the reset falls between a transfer's first clock and judgement.
// - A frame starting with 11 is a syntax error and earns the syntax-error reply.
// - A frame starting with 00 is a syntax error and earns the syntax-error reply, unless it ends in 01, which makes it a diagnosis frame.
// - A read or write of a reserved or unused register is a syntax error.
// - Bit 10 of the diagnosis reply is set after a syntax error, and whenever other than 16, 24 or 32 clocks were received;
//   the code judges a transfer with no clock on the previous transfer's count.
// - The post-reset reply carries the error flag and the identification word; the next is plain diagnosis.
// - One bit is shifted in and one shifted out per serial clock, sixteen for a frame.

package spfpc_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_W = 16;
  localparam int OP_HI = 15;
  localparam int OP_LO = 14;
  localparam int ADDR0_HI = 13;
  localparam int ADDR0_LO = 10;
  localparam int ADDR1_HI = 9;
  localparam int ADDR1_LO = 8;
  localparam int DATA_HI = 7;
  localparam int DATA_LO = 0;
  localparam int ERR_FLAG_BIT = 10;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int DEPTH = 16;

  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] TAIL_READ = 2'h2;
  localparam logic [1:0] TAIL_DIAG = 2'h1;
  localparam logic [1:0] ADDR1_USED = 2'h0;
  // Registers at ADDR0 12..15 are unused
  localparam logic [15:0] ADDR0_USED = 16'h0fff;

  // ----------------------------------------------------------------
  // Frame length
  // ----------------------------------------------------------------
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] LEN_MIN = 6'h10;
  localparam logic [CNT_W-1:0] LEN_MID = 6'h18;
  localparam logic [CNT_W-1:0] LEN_MAX = 6'h20;
  localparam logic [CNT_W-1:0] CNT_SAT = 6'h3f;
  localparam logic [CNT_W-1:0] CNT_RST = 6'h00;

  typedef enum logic [1:0] {CMD_DIAG, CMD_READ, CMD_WRITE, CMD_SYNTAX} spfpc_cmd_e;
  typedef enum {ST_IDLE, ST_EVAL, ST_READ} spfpc_state_e;

  function automatic logic spfpc_len_ok(input logic [CNT_W-1:0] len);
    spfpc_len_ok = (len == LEN_MIN) || (len == LEN_MID) || (len == LEN_MAX);
  endfunction

  function automatic logic spfpc_reg_used(input logic [FRAME_W-1:0] w);
    spfpc_reg_used = ADDR0_USED[w[ADDR0_HI:ADDR0_LO]] && (w[ADDR1_HI:ADDR1_LO] == ADDR1_USED);
  endfunction

  function automatic spfpc_cmd_e spfpc_decode(input logic [FRAME_W-1:0] w);
    logic [1:0] op;
    logic [1:0] tail;
    op = w[OP_HI:OP_LO];
    tail = w[1:0];
    if (!op[1] && tail == TAIL_DIAG)
      spfpc_decode = CMD_DIAG;
    else if (op == OP_READ && tail == TAIL_READ && spfpc_reg_used(w))
      spfpc_decode = CMD_READ;
    else if (op == OP_WRITE && spfpc_reg_used(w))
      spfpc_decode = CMD_WRITE;
    else
      spfpc_decode = CMD_SYNTAX;
  endfunction

  function automatic logic [FRAME_W-1:0] spfpc_diag(input logic [14:0] st, input logic err);
    logic [FRAME_W-1:0] w;
    w = {1'b0, st};
    w[ERR_FLAG_BIT] = err;
    spfpc_diag = w;
  endfunction

endpackage

//--- spfpc_mem_if.sv
// Port bundle between the frame checker and its register store.
// Assumes one write and one read port on ref_clk.
`timescale 1ns/1ns
interface spfpc_mem_if;
  import spfpc_pkg::*;
  logic we;
  logic [ADDR_W-1:0] waddr;
  logic [DATA_W-1:0] wdata;
  logic re;
  logic [ADDR_W-1:0] raddr;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output re, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface

//--- spfpc_regmem.sv
// Register store of the device: 16 words of 8 bits, registered read data.
// Assumes synchronous use on ref_clk; contents carry no reset.
`timescale 1ns/1ns
module spfpc_regmem (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Access port
  spfpc_mem_if.mem port
);
  import spfpc_pkg::*;

  logic [DATA_W-1:0] mem_reg [DEPTH];
  logic [DATA_W-1:0] rdata_reg;

  assign port.rdata = rdata_reg;

  always_ff @(posedge ref_clk) begin
    if (port.we) begin
      mem_reg[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (port.re) begin
      rdata_reg <= mem_reg[port.raddr];
    end
  end
endmodule

//--- spfpc_checker.sv
// SPI frame protocol checker: shifts frames on the link clock, judges them at
// chip select release on ref_clk and prepares the deferred reply.
// Assumes chip select stays high for at least 8 ref_clk cycles between frames.
`timescale 1ns/1ns
module spfpc_checker #(
  // Identification word, value arbitrary
  parameter logic [15:0] IDENT_WORD = 16'h0123
) (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic link_sclk,
  // Link pins
  input wire logic chip_select_low,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en_n,
  // Device side
  input wire logic [14:0] diag_status,
  input wire logic sw_reset
);
  import spfpc_pkg::*;

  localparam logic [FRAME_W-1:0] POST_RESET_WORD = IDENT_WORD | (16'h0001 << ERR_FLAG_BIT);

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  logic in_frame_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [FRAME_W-1:0] shift_reg;
  logic [FRAME_W-1:0] reply_reg;
  wire link_clr_n = rst_n & ~chip_select_low;
  wire [CNT_W-1:0] cnt_next = in_frame_reg ? ((cnt_reg == CNT_SAT) ? cnt_reg : cnt_reg + 6'h01)
                                           : 6'h01;
  wire [FRAME_W-1:0] shift_next = in_frame_reg ? {shift_reg[14:0], serial_in}
                                               : {reply_reg[14:0], serial_in};

  // Reply word is quasi-static while chip select is low
  assign serial_out = in_frame_reg ? shift_reg[FRAME_W-1] : reply_reg[FRAME_W-1];
  assign serial_out_en_n = chip_select_low;

  always_ff @(negedge link_sclk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= 1'b1;
    end
  end

  always_ff @(negedge link_sclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= CNT_RST;
      shift_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
    end
  end

  // ----------------------------------------------------------------
  // Chip select crossing
  // ----------------------------------------------------------------
  logic cs_meta_reg;
  logic cs_sync_reg;
  logic cs_prev_reg;
  wire cs_rise = cs_sync_reg & ~cs_prev_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
    end else begin
      cs_meta_reg <= chip_select_low;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // Frame judgement
  // ----------------------------------------------------------------
  spfpc_state_e state_reg;
  spfpc_state_e state_next;
  logic [FRAME_W-1:0] cap_word_reg;
  logic [CNT_W-1:0] cap_len_reg;
  logic [FRAME_W-1:0] reply_next;
  spfpc_mem_if mem_port ();

  wire len_ok = spfpc_len_ok(cap_len_reg);
  wire spfpc_cmd_e cmd = spfpc_decode(cap_word_reg);
  wire evaluating = (state_reg == ST_EVAL);
  wire do_write = evaluating && len_ok && (cmd == CMD_WRITE);
  wire do_read = evaluating && len_ok && (cmd == CMD_READ);
  wire bad_frame = !len_ok || (cmd == CMD_SYNTAX);
  wire [FRAME_W-1:0] read_word = {OP_WRITE, cap_word_reg[ADDR0_HI:ADDR1_LO], mem_port.rdata};

  assign mem_port.we = do_write;
  assign mem_port.waddr = cap_word_reg[ADDR0_HI:ADDR0_LO];
  assign mem_port.wdata = cap_word_reg[DATA_HI:DATA_LO];
  assign mem_port.re = do_read;
  assign mem_port.raddr = cap_word_reg[ADDR0_HI:ADDR0_LO];

  always_comb begin
    state_next = state_reg;
    reply_next = reply_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (cs_rise) begin
          state_next = ST_EVAL;
        end
      end
      ST_EVAL: begin
        state_next = do_read ? ST_READ : ST_IDLE;
        if (!do_read) begin
          reply_next = spfpc_diag(diag_status, bad_frame);
        end
      end
      ST_READ: begin
        state_next = ST_IDLE;
        reply_next = read_word;
      end
    endcase
    if (sw_reset) begin
      reply_next = POST_RESET_WORD;
      // Pending read must not overwrite the post-reset word
      if (state_reg == ST_EVAL) begin
        state_next = ST_IDLE;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      reply_reg <= POST_RESET_WORD;
      cap_word_reg <= '0;
      cap_len_reg <= CNT_RST;
    end else begin
      state_reg <= state_next;
      reply_reg <= reply_next;
      if (cs_rise) begin
        cap_word_reg <= shift_reg;
        cap_len_reg <= cnt_reg;
      end
    end
  end

  spfpc_regmem u_regmem (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .port(mem_port.mem)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_eval_bad;
    evaluating && bad_frame;
  endsequence

  sequence s_eval_read;
    evaluating && do_read ##1 (state_reg == ST_READ);
  endsequence

  frame_len_err_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (evaluating && !len_ok && !sw_reset) |=> reply_reg[ERR_FLAG_BIT] && !reply_reg[15])
    else $error("length error reply lacks error flag");

  syntax_11_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (evaluating && len_ok && cap_word_reg[15:14] == 2'h3 && !sw_reset) |=> reply_reg[ERR_FLAG_BIT])
    else $error("11 prefix not answered as syntax error");

  syntax_00_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (evaluating && cap_word_reg[15:14] == 2'h0 && cap_word_reg[1:0] != TAIL_DIAG)
    |-> cmd == CMD_SYNTAX && !mem_port.we)
    else $error("00 prefix accepted");

  reserved_reg_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (evaluating && cap_word_reg[15:14] != 2'h0 && !spfpc_reg_used(cap_word_reg))
    |-> !mem_port.we && !mem_port.re)
    else $error("reserved register accessed");

  no_write_err_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_eval_bad |-> !mem_port.we)
    else $error("register written on bad frame");

  read_reply_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_eval_read ##0 !sw_reset |=> reply_reg[15:14] == OP_WRITE
      && reply_reg[13:8] == $past(cap_word_reg[13:8], 2))
    else $error("read reply malformed");

  reply_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!cs_sync_reg && !cs_prev_reg && state_reg == ST_IDLE && !sw_reset) |=> $stable(reply_reg))
    else $error("reply changed during transfer");

  eval_at_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    evaluating |-> $past(cs_rise) && cs_prev_reg)
    else $error("judged outside chip select release");

  good_diag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (evaluating && len_ok && cmd == CMD_DIAG && !sw_reset) |=> !reply_reg[ERR_FLAG_BIT])
    else $error("error flag set on good frame");

  post_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sw_reset |=> reply_reg == POST_RESET_WORD)
    else $error("post-reset reply missing");

  bit_count_a: assert property (@(negedge link_sclk) disable iff (!rst_n)
    (in_frame_reg && cnt_reg < 6'h3e) |=> cnt_reg == $past(cnt_reg) + 6'h01)
    else $error("bit count skipped");
endmodule

//--- spfpc_host.sv
// Host model: link master that frames commands and collects replies.
// Assumes the device samples serial_in and shifts serial_out on falling link_sclk.
`timescale 1ns/1ns
module spfpc_host (
  // Link pins
  output logic link_sclk,
  output logic chip_select_low,
  output logic serial_in,
  // Reply pin
  input wire logic serial_out
);
  // Clock stands low between frames, input line is pulled down
  initial begin
    link_sclk = 1'b0;
    chip_select_low = 1'b1;
    serial_in = 1'b0;
  end

  // ----------------------------------------------------------------
  // One frame of n clocks, first 16 reply bits kept
  // ----------------------------------------------------------------
  task automatic xfer(input logic [31:0] cmd, input int n, output logic [15:0] rsp);
    rsp = 16'h0000;
    #3 chip_select_low = 1'b0;
    #30;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = (i < 32) ? cmd[i] : 1'b0;
      #4 link_sclk = 1'b1;
      if (n - 1 - i < 16)
        rsp[15 - (n - 1 - i)] = serial_out;
      #8 link_sclk = 1'b0;
      #3;
    end
    #20 chip_select_low = 1'b1;
    serial_in = 1'b0;
    #400;
  endtask
endmodule

//--- spi_frame_protocol_checker_tb_top.sv
// Testbench top for the SPI frame protocol checker.
// Assumes spfpc_host as the only master on the link.
`timescale 1ns/1ns
module spi_frame_protocol_checker_tb_top;
  import spfpc_pkg::*;
  localparam logic [15:0] IDENT = 16'h3896; // Arbitrary value
  localparam logic [15:0] DG = 16'h0001;
  localparam logic [15:0] WR3 = 16'h8ca5;
  localparam logic [15:0] RD3 = 16'h4c02;
  localparam logic [14:0] DS = 15'h2fcd;
  logic ref_clk;
  logic rst_n;
  logic sw_reset;
  logic [14:0] diag_status;
  logic link_sclk;
  logic chip_select_low;
  logic serial_in;
  logic serial_out;
  logic serial_out_en_n;
  logic [15:0] rsp;
  int errors;
  int checks;

  spfpc_checker #(.IDENT_WORD(IDENT)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .link_sclk(link_sclk), .chip_select_low(chip_select_low), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en_n(serial_out_en_n),
    .diag_status(diag_status), .sw_reset(sw_reset));
  spfpc_host host (.link_sclk(link_sclk), .chip_select_low(chip_select_low),
    .serial_in(serial_in), .serial_out(serial_out));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] diag(input logic flag);
    diag = {1'b0, DS[14:11], flag, DS[9:0]};
  endfunction

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic x(input logic [31:0] cmd, input int n);
    host.xfer(cmd, n, rsp);
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_post_reset;
    x(DG, 16);
    chk("post reset reply", rsp, IDENT | 16'h0400);
    chk("output enable", {15'h0000, serial_out_en_n}, 16'h0001);
    x(16'h7ff1, 16);
    chk("second reply", rsp, diag(1'b0));
    x(DG, 16);
    chk("diag 01 reply", rsp, diag(1'b0));
    $display("test post_reset done");
  endtask

  task automatic t_write_read;
    x(WR3, 16);
    x(RD3, 16);
    chk("write answer", rsp, diag(1'b0));
    x(DG, 16);
    chk("read answer", rsp, WR3);
    $display("test write_read done");
  endtask

  task automatic t_length;
    int n[8] = '{8, 15, 17, 23, 33, 40, 24, 32};
    for (int k = 0; k < 8; k++) begin
      x({16'h0000, DG}, n[k]);
      x(DG, 16);
      chk("length reply", rsp, diag(k < 6));
    end
    $display("test length done");
  endtask

  task automatic t_syntax;
    logic [15:0] f[5] = '{16'hcc5a, 16'h0c02, 16'hb011, 16'h4d02, 16'h8c5a};
    for (int k = 0; k < 5; k++) begin
      x({16'h0000, f[k]}, (k == 4) ? 17 : 16);
      x(DG, 16);
      chk("syntax reply", rsp, diag(1'b1));
    end
    x(RD3, 16);
    x(DG, 16);
    chk("register kept", rsp, WR3);
    $display("test syntax done");
  endtask

  task automatic t_sw_reset;
    @(posedge ref_clk);
    sw_reset <= 1'b1;
    @(posedge ref_clk);
    sw_reset <= 1'b0;
    x(DG, 16);
    chk("soft reset reply", rsp, IDENT | 16'h0400);
    x(DG, 16);
    chk("after soft reset", rsp, diag(1'b0));
    $display("test sw_reset done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    checks = 0;
    rst_n = 1'b0;
    sw_reset = 1'b0;
    diag_status = DS;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_post_reset();
    t_write_read();
    t_length();
    t_syntax();
    t_sw_reset();
    summarize();
  end

  initial begin
    #200000;
    errors++;
    summarize();
  end
endmodule
